// [hw/tmr8_timer.sv]
// 8-bit timer/counter with two compare channels, waveform modes and APB registers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_regs.svh"
module tmr8_timer
	import tmr8_pkg::*;
#(
	parameter int CLK_HZ = 25000000
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe
);
	logic [10:0] ctrl_reg;
	logic [7:0] cmpa_reg;
	logic [7:0] cmpb_reg;
	logic [7:0] bufa_reg;
	logic [7:0] bufb_reg;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [2:0] flag_reg;
	logic [1:0] state_reg;
	logic [1:0] state_next;
	tmr8_pin_s pin_reg;
	logic [9:0] pre_reg;
	logic block_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	logic wr;
	logic rd;
	logic tick;
	logic [2:0] mode;
	tmr8_seq_e seq;
	logic [7:0] top;
	logic at_top;
	logic wrap;
	logic [1:0] match;
	logic [1:0] force_hit;
	logic [1:0] act [2];
	logic [7:0] cmp [2];

	function automatic tmr8_seq_e seq_of(input logic [2:0] m);
		unique case (m)
			`TMR8_MODE_NORMAL: seq_of = TMR8_SEQ_NORMAL;
			`TMR8_MODE_CLRMATCH: seq_of = TMR8_SEQ_CLRMATCH;
			`TMR8_MODE_FPWM, `TMR8_MODE_FPWM_A: seq_of = TMR8_SEQ_FPWM;
			default: seq_of = TMR8_SEQ_OTHER;
		endcase
	endfunction

	// prescaler select: 0 stop, 1..5 = 1, 8, 64, 256, 1024
	function automatic logic pre_tick(input logic [2:0] s, input logic [9:0] p);
		unique case (s)
			`TMR8_PRE_DIV1: pre_tick = 1'b1;
			`TMR8_PRE_DIV8: pre_tick = ((p & `TMR8_PRE_LAST8) == `TMR8_PRE_LAST8);
			`TMR8_PRE_DIV64: pre_tick = ((p & `TMR8_PRE_LAST64) == `TMR8_PRE_LAST64);
			`TMR8_PRE_DIV256: pre_tick = ((p & `TMR8_PRE_LAST256) == `TMR8_PRE_LAST256);
			`TMR8_PRE_DIV1024: pre_tick = (p == `TMR8_PRE_LAST1024);
			default: pre_tick = 1'b0;
		endcase
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign mode = ctrl_reg[`TMR8_F_MODE];
	assign seq = seq_of(mode);
	assign tick = pre_tick(ctrl_reg[`TMR8_F_PSEL], pre_reg);
	assign act[0] = ctrl_reg[`TMR8_F_ACTA];
	assign act[1] = ctrl_reg[`TMR8_F_ACTB];
	assign cmp[0] = cmpa_reg;
	assign cmp[1] = cmpb_reg;
	// top is compare A in clear-on-match and mode 7, else 0xff
	assign top = (seq == TMR8_SEQ_CLRMATCH || mode == `TMR8_MODE_FPWM_A) ? cmpa_reg : `TMR8_MAX;
	assign at_top = (count_reg == top);
	assign wrap = tick && at_top && (seq == TMR8_SEQ_FPWM);
	assign force_hit[0] = wr && paddr == `TMR8_A_FORCE && pwdata[`TMR8_B_FORCEA] && seq != TMR8_SEQ_FPWM;
	assign force_hit[1] = wr && paddr == `TMR8_A_FORCE && pwdata[`TMR8_B_FORCEB] && seq != TMR8_SEQ_FPWM;

	// matches are evaluated on the timer tick and masked after a count write
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_match
			assign match[i] = tick && !block_reg && (count_reg == cmp[i]);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_reg <= `TMR8_PRE_RST;
		else if (ctrl_reg[`TMR8_F_PSEL] == `TMR8_PRE_STOP)
			pre_reg <= `TMR8_PRE_RST;
		else
			pre_reg <= pre_reg + 10'h001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= `TMR8_CTRL_RST;
		else if (wr && paddr == `TMR8_A_CTRL)
			ctrl_reg <= pwdata[10:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_reg <= '0;
		else if (wr && paddr == `TMR8_A_PORT)
			pin_reg <= pwdata[3:0];
	end

	// writes land in the buffer in PWM, directly otherwise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bufa_reg <= 8'h00;
			bufb_reg <= 8'h00;
		end
		else
		begin
			if (wr && paddr == `TMR8_A_CMPA)
				bufa_reg <= pwdata[7:0];
			if (wr && paddr == `TMR8_A_CMPB)
				bufb_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmpa_reg <= 8'h00;
			cmpb_reg <= 8'h00;
		end
		else if (seq == TMR8_SEQ_FPWM)
		begin
			if (wrap)
			begin
				cmpa_reg <= bufa_reg;
				cmpb_reg <= bufb_reg;
			end
		end
		else
		begin
			if (wr && paddr == `TMR8_A_CMPA)
				cmpa_reg <= pwdata[7:0];
			if (wr && paddr == `TMR8_A_CMPB)
				cmpb_reg <= pwdata[7:0];
		end
	end

	// a clear-on-match top below the count is missed; count runs through 0xff
	always_comb
	begin
		count_next = count_reg;
		if (tick)
		begin
			if ((seq == TMR8_SEQ_CLRMATCH && match[0]) || wrap)
				count_next = `TMR8_BOTTOM;
			else
				count_next = count_reg + 8'h01;
		end
	end

	// software write to the count wins over counting and arms the match blocker
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= `TMR8_BOTTOM;
		else if (wr && paddr == `TMR8_A_COUNT)
			count_reg <= pwdata[7:0];
		else
			count_reg <= count_next;
	end

	// blocker spans up to and including the next timer tick, even if stopped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			block_reg <= 1'b0;
		else if (wr && paddr == `TMR8_A_COUNT)
			block_reg <= 1'b1;
		else if (tick)
			block_reg <= 1'b0;
	end

	// flags: hardware set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_reg <= 3'h0;
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (wr && paddr == `TMR8_A_FLAGS && pwdata[i])
					flag_reg[i] <= 1'b0;
			end
			if (tick && seq == TMR8_SEQ_FPWM && count_next == top)
				flag_reg[`TMR8_B_OVF] <= 1'b1;
			if (tick && seq != TMR8_SEQ_FPWM && count_reg == `TMR8_MAX && count_next == `TMR8_BOTTOM)
				flag_reg[`TMR8_B_OVF] <= 1'b1;
			if (match[0])
				flag_reg[`TMR8_B_CFA] <= 1'b1;
			if (match[1])
				flag_reg[`TMR8_B_CFB] <= 1'b1;
		end
	end

	// waveform generator per channel; action 0 leaves the bit alone
	always_comb
	begin
		state_next = state_reg;
		for (int i = 0; i < 2; i++)
		begin
			if (seq == TMR8_SEQ_FPWM)
			begin
				// compare equal to top with clear/set action: match ignored, only wrap acts
				if (match[i] && !(act[i][1] && cmp[i] == top))
				begin
					if (act[i] == `TMR8_ACT_CLR)
						state_next[i] = 1'b0;
					else if (act[i] == `TMR8_ACT_SET)
						state_next[i] = 1'b1;
					else if (act[i] == `TMR8_ACT_TOG && i == 0 && mode[`TMR8_B_TOPSEL])
						state_next[i] = !state_reg[i];
				end
				if (wrap && act[i][1])
					state_next[i] = (act[i] == `TMR8_ACT_CLR);
			end
			else if (match[i] || force_hit[i])
			begin
				unique case (act[i])
					`TMR8_ACT_TOG: state_next[i] = !state_reg[i];
					`TMR8_ACT_CLR: state_next[i] = 1'b0;
					`TMR8_ACT_SET: state_next[i] = 1'b1;
					`TMR8_ACT_OFF: state_next[i] = state_reg[i];
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= 2'h0;
		else
			state_reg <= state_next;
	end

	// pin override independent of mode; direction always from the dir bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out <= 2'h0;
			pin_oe <= 2'h0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				pin_out[i] <= (act[i] != `TMR8_ACT_OFF) ? state_next[i] : pin_reg.port[i];
				pin_oe[i] <= pin_reg.dir[i];
			end
		end
	end

	// APB: zero wait, read data captured in setup, unmapped reads zero with error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h0;
			pslverr_reg <= 1'b0;
			pready_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= psel && !penable;
			pslverr_reg <= psel && !penable && (paddr > `TMR8_A_PINS || paddr[1:0] != 2'h0);
			if (rd)
			begin
				unique case (paddr)
					`TMR8_A_CTRL: prdata_reg <= {21'h0, ctrl_reg};
					`TMR8_A_CMPA: prdata_reg <= {24'h0, bufa_reg};
					`TMR8_A_CMPB: prdata_reg <= {24'h0, bufb_reg};
					`TMR8_A_COUNT: prdata_reg <= {24'h0, count_reg};
					`TMR8_A_FLAGS: prdata_reg <= {29'h0, flag_reg};
					`TMR8_A_PORT: prdata_reg <= {28'h0, pin_reg};
					`TMR8_A_PINS: prdata_reg <= {28'h0, pin_out, state_reg};
					default: prdata_reg <= 32'h0;
				endcase
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	property p_reset_state;
		@(posedge pclk) $rose(presetn) |-> state_reg == 2'h0;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state bits not cleared by reset");

	property p_override;
		@(posedge pclk) disable iff (!presetn)
		(act[0] != `TMR8_ACT_OFF) |=> pin_out[0] == state_reg[0];
	endproperty
	a_override: assert property (p_override) else $error("pin A not following state bit");

	property p_off_hold;
		@(posedge pclk) disable iff (!presetn)
		(act[1] == `TMR8_ACT_OFF && seq != TMR8_SEQ_FPWM) |=> $stable(state_reg[1]);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("state B changed with action off");

	property p_normal_wrap;
		@(posedge pclk) disable iff (!presetn)
		(tick && seq == TMR8_SEQ_NORMAL && count_reg == `TMR8_MAX && !wr)
		|=> count_reg == `TMR8_BOTTOM && flag_reg[`TMR8_B_OVF];
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow flag wrong");

	property p_ctc_clear;
		@(posedge pclk) disable iff (!presetn)
		(seq == TMR8_SEQ_CLRMATCH && match[0] && !wr) |=> count_reg == `TMR8_BOTTOM && flag_reg[`TMR8_B_CFA];
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match did not clear");

	property p_ctc_toggle;
		@(posedge pclk) disable iff (!presetn)
		(seq == TMR8_SEQ_CLRMATCH && match[0] && act[0] == `TMR8_ACT_TOG) |=> state_reg[0] != $past(state_reg[0]);
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle) else $error("channel A did not toggle");

	property p_pwm_wrap_set;
		@(posedge pclk) disable iff (!presetn)
		// a count write in the wrap cycle wins over the clear
		(wrap && act[0] == `TMR8_ACT_CLR && !(wr && paddr == `TMR8_A_COUNT))
		|=> state_reg[0] && count_reg == `TMR8_BOTTOM;
	endproperty
	a_pwm_wrap_set: assert property (p_pwm_wrap_set) else $error("fast pwm wrap did not set A");

	property p_cmp_flag;
		@(posedge pclk) disable iff (!presetn)
		match[1] |=> flag_reg[`TMR8_B_CFB];
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag B not set on match");

	property p_block;
		@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `TMR8_A_COUNT) |=> !match[0] && !match[1];
	endproperty
	a_block: assert property (p_block) else $error("match not blocked after count write");

	property p_force_noflag;
		@(posedge pclk) disable iff (!presetn)
		(force_hit[0] && !match[0] && !flag_reg[`TMR8_B_CFA]) |=> !flag_reg[`TMR8_B_CFA];
	endproperty
	a_force_noflag: assert property (p_force_noflag) else $error("force set compare flag");
endmodule
`default_nettype wire

// [hw/tmr8_regs.svh]
// register offsets, field positions and reset values of the 8-bit compare timer
// Notes on behaviour
// - reset clears both internal compare state bits to zero.
// - nonzero action field routes state bit to pin; direction bit still gates driving.
// - pin override ignores waveform mode, depends only on action field.
// - action zero leaves the state bit untouched at any match.
// - new action acts at next match; force strobe acts at once in non-PWM modes.
// - mode field alone picks count sequence; action only picks output behaviour.
// - mode 0 counts up forever, wrapping 0xff to 0x00.
// - normal mode sets overflow flag as count becomes zero; only software clears it.
// - mode 2 clears count when it equals compare value A.
// - clear-on-match mode sets compare flag A at each top.
// - clear-on-match compare A is unbuffered; low write means run to 0xff first.
// - clear-on-match action 1 toggles channel A at each match.
// - toggle frequency is io clock over 2 times prescale times (1+A).
// - clear-on-match mode sets overflow flag on 0xff to 0x00.
// - modes 3 and 7 are fast PWM; top 0xff or compare value A.
// - fast PWM counts to top then clears next timer tick.
// - fast PWM action 2 clears on match sets at wrap; 3 inverse.
// - fast PWM action 1 toggles channel A only with top-select bit; never B.
// - fast PWM sets overflow flag each time count reaches top.
// - fixed-top fast PWM period is 256 timer ticks.
// - compare zero gives one-tick spike; compare max gives constant level.
// - compare values double buffered in PWM modes, direct otherwise.
// - compare flag set on tick after count equals compare; write one clears.
// - forced compare updates state bit only, no flag, no counter change.
// - count write blocks all compare matches in the next timer tick.
`ifndef TMR8_REGS_SVH
`define TMR8_REGS_SVH
`define TMR8_A_CTRL 12'h000
`define TMR8_A_CMPA 12'h004
`define TMR8_A_CMPB 12'h008
`define TMR8_A_COUNT 12'h00c
`define TMR8_A_FLAGS 12'h010
`define TMR8_A_FORCE 12'h014
`define TMR8_A_PORT 12'h018
`define TMR8_A_PINS 12'h01c
`define TMR8_F_MODE 2:0
`define TMR8_F_ACTB 5:4
`define TMR8_F_ACTA 7:6
`define TMR8_F_PSEL 10:8
`define TMR8_B_TOPSEL 2
`define TMR8_B_OVF 0
`define TMR8_B_CFA 1
`define TMR8_B_CFB 2
`define TMR8_B_FORCEA 0
`define TMR8_B_FORCEB 1
`define TMR8_B_STATEA 0
`define TMR8_B_STATEB 1
`define TMR8_B_PINA 2
`define TMR8_B_PINB 3
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_ACT_OFF 2'h0
`define TMR8_ACT_TOG 2'h1
`define TMR8_ACT_CLR 2'h2
`define TMR8_ACT_SET 2'h3
`define TMR8_MODE_NORMAL 3'h0
`define TMR8_MODE_CLRMATCH 3'h2
`define TMR8_MODE_FPWM 3'h3
`define TMR8_MODE_FPWM_A 3'h7
`define TMR8_CTRL_RST 11'h000
`define TMR8_PRE_STOP 3'h0
`define TMR8_PRE_DIV1 3'h1
`define TMR8_PRE_DIV8 3'h2
`define TMR8_PRE_DIV64 3'h3
`define TMR8_PRE_DIV256 3'h4
`define TMR8_PRE_DIV1024 3'h5
`define TMR8_PRE_LAST8 10'h007
`define TMR8_PRE_LAST64 10'h03f
`define TMR8_PRE_LAST256 10'h0ff
`define TMR8_PRE_LAST1024 10'h3ff
`define TMR8_PRE_RST 10'h000
`endif

// [hw/tmr8_pkg.sv]
// types shared by the 8-bit compare timer
package tmr8_pkg;
	typedef struct packed {
		logic [1:0] dir;
		logic [1:0] port;
	} tmr8_pin_s;
	typedef enum logic [1:0] {
		TMR8_SEQ_NORMAL = 2'h0,
		TMR8_SEQ_CLRMATCH = 2'h1,
		TMR8_SEQ_FPWM = 2'h3,
		TMR8_SEQ_OTHER = 2'h2
	} tmr8_seq_e;
endpackage

// [tb/tmr8_testbench.sv]
// self-checking bench for the 8-bit compare timer over its register bus
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_regs.svh"
module testbench
	import tmr8_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0] pin_out, pin_oe;
	int n_fail, checks, hi, per;

	tmr8_timer tmr8_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic close_out;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one transfer; waits for pready however long the slave takes
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask

	function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] a, input logic [1:0] b,
		input logic [2:0] p);
		return {21'h0, p, a, b, 1'b0, m};
	endfunction

	// skips one period so a mode change has settled, then times high phase and period
	task automatic meas(input int i);
		int n;
		n = 0;
		repeat (2)
		begin
			while (pin_out[i] !== 1'b0 && n < 3000)
			begin
				@(posedge pclk);
				n++;
			end
			while (pin_out[i] !== 1'b1 && n < 3000)
			begin
				@(posedge pclk);
				n++;
			end
		end
		hi = 0;
		per = 0;
		while (pin_out[i] === 1'b1 && per < 3000)
		begin
			@(posedge pclk);
			hi++;
			per++;
		end
		while (pin_out[i] === 1'b0 && per < 3000)
		begin
			@(posedge pclk);
			per++;
		end
	endtask

	task automatic stay(input int i, input int k);
		logic v;
		int c;
		v = pin_out[i];
		c = 0;
		repeat (k)
		begin
			@(posedge pclk);
			if (pin_out[i] !== v)
				c++;
		end
		chk(c, 0);
	endtask

	initial
	begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		close_out;
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_fail = 0;
		checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`TMR8_A_PINS, 32'hf, 32'h0);
		rdc(`TMR8_A_CTRL, 32'h7ff, 32'h0);
		$display("test reset done");
		// port register: direction in [3:2], level in [1:0]
		apb(1'b1, `TMR8_A_PORT, 32'hd);
		repeat (2) @(posedge pclk);
		chk(pin_oe, 32'h3);
		chk(pin_out, 32'h1);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_NORMAL, `TMR8_ACT_SET, `TMR8_ACT_CLR, 3'h0));
		repeat (2) @(posedge pclk);
		chk(pin_out, 32'h0);
		apb(1'b1, `TMR8_A_FORCE, 32'h3);
		repeat (2) @(posedge pclk);
		chk(pin_out, 32'h1);
		rdc(`TMR8_A_FLAGS, 32'h7, 32'h0);
		rdc(`TMR8_A_COUNT, 32'hff, 32'h0);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_SET, `TMR8_ACT_CLR, 3'h0));
		repeat (2) @(posedge pclk);
		chk(pin_out, 32'h1);
		apb(1'b1, `TMR8_A_CTRL, 32'h0);
		apb(1'b1, `TMR8_A_FORCE, 32'h3);
		rdc(`TMR8_A_PINS, 32'h3, 32'h1);
		apb(1'b1, `TMR8_A_PORT, 32'h1);
		repeat (2) @(posedge pclk);
		chk(pin_oe, 32'h0);
		apb(1'b1, `TMR8_A_PORT, 32'hd);
		$display("test pin override done");
		apb(1'b1, `TMR8_A_FLAGS, 32'h7);
		apb(1'b1, `TMR8_A_COUNT, 32'hfd);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_NORMAL, 2'h0, 2'h0, 3'h1));
		repeat (10) @(posedge pclk);
		apb(1'b1, `TMR8_A_CTRL, 32'h0);
		rdc(`TMR8_A_FLAGS, 32'h1, 32'h1);
		apb(1'b0, `TMR8_A_COUNT, 32'h0);
		chk(q < 32'h20, 32'h1);
		// count write equal to compare must not raise the flag
		apb(1'b1, `TMR8_A_FLAGS, 32'h7);
		apb(1'b1, `TMR8_A_CMPB, 32'h30);
		apb(1'b1, `TMR8_A_COUNT, 32'h30);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_NORMAL, 2'h0, 2'h0, 3'h1));
		repeat (5) @(posedge pclk);
		apb(1'b1, `TMR8_A_CTRL, 32'h0);
		rdc(`TMR8_A_FLAGS, 32'h4, 32'h0);
		apb(1'b1, `TMR8_A_COUNT, 32'h2e);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_NORMAL, 2'h0, 2'h0, 3'h1));
		repeat (8) @(posedge pclk);
		apb(1'b1, `TMR8_A_CTRL, 32'h0);
		rdc(`TMR8_A_FLAGS, 32'h4, 32'h4);
		$display("test normal mode done");
		apb(1'b1, `TMR8_A_FLAGS, 32'h7);
		apb(1'b1, `TMR8_A_CMPA, 32'h3);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h1));
		meas(0);
		chk(hi, 32'd4);
		chk(per, 32'd8);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h2));
		meas(0);
		chk(hi, 32'd32);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h0));
		apb(1'b0, `TMR8_A_COUNT, 32'h0);
		chk(q <= 32'h3, 32'h1);
		rdc(`TMR8_A_FLAGS, 32'h3, 32'h3);
		// compare written below the count: no match until after the wrap
		apb(1'b1, `TMR8_A_COUNT, 32'h10);
		apb(1'b1, `TMR8_A_CMPA, 32'h5);
		apb(1'b1, `TMR8_A_FLAGS, 32'h7);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h1));
		repeat (100) @(posedge pclk);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h0));
		rdc(`TMR8_A_FLAGS, 32'h3, 32'h0);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h1));
		repeat (200) @(posedge pclk);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_CLRMATCH, `TMR8_ACT_TOG, 2'h0, 3'h0));
		rdc(`TMR8_A_FLAGS, 32'h3, 32'h3);
		$display("test clear on match done");
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_FPWM, 2'h0, 2'h0, 3'h0));
		apb(1'b1, `TMR8_A_CMPA, 32'h40);
		apb(1'b1, `TMR8_A_CMPB, 32'hc0);
		apb(1'b1, `TMR8_A_FLAGS, 32'h7);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_FPWM, `TMR8_ACT_CLR, `TMR8_ACT_SET, 3'h1));
		meas(0);
		chk(hi, 32'h41);
		chk(per, 32'd256);
		meas(1);
		chk(hi, 32'h3f);
		rdc(`TMR8_A_FLAGS, 32'h1, 32'h1);
		apb(1'b1, `TMR8_A_CMPA, 32'h80);
		rdc(`TMR8_A_CMPA, 32'hff, 32'h80);
		meas(0);
		chk(hi, 32'h81);
		apb(1'b1, `TMR8_A_CMPA, 32'h0);
		meas(0);
		chk(hi, 32'd1);
		chk(per, 32'd256);
		apb(1'b1, `TMR8_A_CMPA, 32'hff);
		repeat (300) @(posedge pclk);
		chk(pin_out[0], 32'h1);
		stay(0, 300);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_FPWM, `TMR8_ACT_TOG, `TMR8_ACT_TOG, 3'h1));
		stay(0, 600);
		apb(1'b1, `TMR8_A_CMPA, 32'h9);
		apb(1'b1, `TMR8_A_CTRL, ctl(`TMR8_MODE_FPWM_A, `TMR8_ACT_TOG, `TMR8_ACT_TOG, 3'h1));
		meas(0);
		chk(hi, 32'd10);
		chk(per, 32'd20);
		stay(1, 300);
		$display("test fast pwm done");
		apb(1'b0, 12'h020, 32'h0);
		chk(q, 32'h0);
		chk(err, 32'h1);
		apb(1'b1, 12'h022, 32'hff);
		chk(err, 32'h1);
		$display("test unmapped done");
		close_out;
	end
endmodule
`default_nettype wire
